//--- verilog/dvirx_pkg.sv
// constants, types and field layout for the dvi receiver output control
// How it works
// [R1] channel 1 carries green when active, first aux control when blanking
// [R2] channel 2 carries red when active, second and third aux control in blank
// [R3] link counts as active only while data enable keeps toggling
// [R4] link-active flag output is high when active, low when inactive
// [R5] system may tie the flag to output power-down for auto shutoff
// [R6] two-pixel mode with stagger low offsets odd output from even output
// [R7] two-pixel mode with stagger high presents even and odd together
// [R8] drive strength output follows the drive strength select bit
// [R9] output clock period is one pixel, or two pixels in two-pixel mode
// [R10] pixel period equals reference clock period, 6.06 ns to 40 ns
// [R11] channel 0 carries blue when active, hsync and vsync in blank
// [R12] mode high gives pixel pairs per clock, low gives sequential even bus
// [R13] one-pixel mode holds the whole odd pixel bus low
// [R14] output power-down floats outputs except flag and first aux control
// [R15] flag clears after a fixed idle time without data enable edges
package dvirx_pkg;

	// pixel and channel layout
	localparam int COLOR_W   = 8;
	localparam int PIX_W     = 24;
	localparam int BLUE_LSB  = 0;
	localparam int GREEN_LSB = 8;
	localparam int RED_LSB   = 16;

	typedef logic [PIX_W-1:0] dvirx_pixel_t;

	// one decoded link word per reference clock
	typedef struct packed {
		logic               de;
		logic [COLOR_W-1:0] ch2_data;
		logic [COLOR_W-1:0] ch1_data;
		logic [COLOR_W-1:0] ch0_data;
		logic [1:0]         ch2_ctl;
		logic [1:0]         ch1_ctl;
		logic [1:0]         ch0_ctl;
	} dvirx_link_s;

	// control register content
	typedef struct packed {
		logic auto_powerdown;
		logic output_drive_powerdown_n;
		logic drive_strength_select;
		logic stagger_select_n;
		logic pixel_mode_select;
	} dvirx_ctrl_s;

	// register map
	localparam int         ADDR_W     = 8;
	localparam int         DATA_W     = 32;
	localparam int         CTRL_W     = 5;
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [4:0] CTRL_RST   = 5'h0A;
	localparam int         STAT_LINK_BIT = 0;
	localparam int         STAT_OE_BIT   = 1;

	// link activity states
	typedef enum logic [1:0] {
		ACT_IDLE = 2'b01,
		ACT_LIVE = 2'b10
	} dvirx_act_e;

	// timing
	localparam int CLK_PERIOD_PS = 40000;
	localparam int TPIX_MIN_PS   = 6060;
	localparam int TPIX_MAX_PS   = 40000;
	localparam int IDLE_TIME_NS  = 100000;
	localparam int IDLE_CYCLES   = IDLE_TIME_NS * 1000 / CLK_PERIOD_PS;
	localparam int IDLE_W        = 12;
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYCLES - 1);

endpackage

//--- verilog/dvirx_apb_regs.sv
// apb slave holding the control and status registers
`timescale 1ns/100ps
module dvirx_apb_regs (
	input  wire logic                        clock,       // system clock
	input  wire logic                        rst,         // sync reset, high
	input  wire logic [dvirx_pkg::ADDR_W-1:0] paddr,      // byte address
	input  wire logic                        psel,        // slave select
	input  wire logic                        penable,     // access phase
	input  wire logic                        pwrite,      // write access
	input  wire logic [dvirx_pkg::DATA_W-1:0] pwdata,     // write data
	output logic      [dvirx_pkg::DATA_W-1:0] prdata,     // read data
	output logic                             pready,      // always ready
	output logic                             pslverr,     // unmapped access
	input  wire logic                        link_active, // status: link
	input  wire logic                        drive_en,    // status: drivers
	output dvirx_pkg::dvirx_ctrl_s           ctrl         // control fields
);

	logic [dvirx_pkg::CTRL_W-1:0] ctrl_reg;
	logic [dvirx_pkg::DATA_W-1:0] prdata_reg;
	logic                         mapped;
	logic                         setup;
	logic                         access;

	// address decode and phases
	assign mapped  = (paddr == dvirx_pkg::CTRL_OFF) ||
	                 (paddr == dvirx_pkg::STATUS_OFF);
	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata  = prdata_reg;
	assign ctrl    = dvirx_pkg::dvirx_ctrl_s'(ctrl_reg);

	// control register write
	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_reg <= dvirx_pkg::CTRL_RST;
		end else if (access && pwrite && paddr == dvirx_pkg::CTRL_OFF) begin
			ctrl_reg <= pwdata[dvirx_pkg::CTRL_W-1:0];
		end
	end

	// read data captured in setup, valid through access
	always_ff @(posedge clock) begin
		if (rst) begin
			prdata_reg <= '0;
		end else if (setup && !pwrite) begin
			prdata_reg <= '0;
			if (paddr == dvirx_pkg::CTRL_OFF) begin
				prdata_reg[dvirx_pkg::CTRL_W-1:0] <= ctrl_reg;
			end else if (paddr == dvirx_pkg::STATUS_OFF) begin
				prdata_reg[dvirx_pkg::STAT_LINK_BIT] <= link_active;
				prdata_reg[dvirx_pkg::STAT_OE_BIT]   <= drive_en;
			end
		end
	end

endmodule

//--- verilog/dvirx_output_control.sv
// dvi receiver output formatting, link activity and drive control
`timescale 1ns/100ps
module dvirx_output_control (
	input  wire logic                        clock,        // system clock
	input  wire logic                        rst,          // sync reset
	input  wire logic [dvirx_pkg::ADDR_W-1:0] paddr,       // apb address
	input  wire logic                        psel,         // apb select
	input  wire logic                        penable,      // apb enable
	input  wire logic                        pwrite,       // apb write
	input  wire logic [dvirx_pkg::DATA_W-1:0] pwdata,      // apb wdata
	output logic      [dvirx_pkg::DATA_W-1:0] prdata,      // apb rdata
	output logic                             pready,       // apb ready
	output logic                             pslverr,      // apb error
	input  wire logic                        link_reference_clock, // link
	input  wire dvirx_pkg::dvirx_link_s      link_in,      // decoded word
	output dvirx_pkg::dvirx_pixel_t          even_pixel_bus, // even pixel
	output dvirx_pkg::dvirx_pixel_t          odd_pixel_bus,  // odd pixel
	output logic                             de_out,       // data enable
	output logic                             hsync_out,    // horiz sync
	output logic                             vsync_out,    // vert sync
	output logic                             aux_control_first,  // ctl 1
	output logic                             aux_control_second, // ctl 2
	output logic                             aux_control_third,  // ctl 3
	output logic                             output_pixel_clock, // pix clk
	output logic                             output_drive_enable, // pad oe
	output logic                             drive_strength_select, // pads
	output logic                             link_active_flag // link live
);

	// pixel word from the three channels
	function automatic dvirx_pkg::dvirx_pixel_t pixel_of(
		input dvirx_pkg::dvirx_link_s w
	);
		dvirx_pkg::dvirx_pixel_t p;
		p = '0;
		p[dvirx_pkg::BLUE_LSB +: dvirx_pkg::COLOR_W]  = w.ch0_data; // R11
		p[dvirx_pkg::GREEN_LSB +: dvirx_pkg::COLOR_W] = w.ch1_data; // R1
		p[dvirx_pkg::RED_LSB +: dvirx_pkg::COLOR_W]   = w.ch2_data; // R2
		return p;
	endfunction

	// system domain
	dvirx_pkg::dvirx_ctrl_s ctrl;
	dvirx_pkg::dvirx_act_e  act_state_reg;
	logic [dvirx_pkg::IDLE_W-1:0] idle_cnt_reg;
	logic                   flag_reg;
	logic                   drive_en_reg;
	logic                   de_tgl_meta;
	logic                   de_tgl_sync;
	logic                   de_tgl_seen;
	logic                   de_evt;

	// link domain
	logic                   link_rst_meta;
	logic                   link_rst_q;
	dvirx_pkg::dvirx_ctrl_s ctrl_meta;
	dvirx_pkg::dvirx_ctrl_s ctrl_lk;
	logic                   en_meta;
	logic                   en_lk;
	logic                   de_prev_reg;
	logic                   de_tgl_reg;
	logic                   pair_odd_reg;
	logic                   stagger_select_n_pend_reg;
	logic                   ck_half_reg;
	dvirx_pkg::dvirx_pixel_t even_hold_reg;
	dvirx_pkg::dvirx_pixel_t odd_hold_reg;
	dvirx_pkg::dvirx_pixel_t even_reg;
	dvirx_pkg::dvirx_pixel_t odd_reg;
	logic                   de_out_reg;
	logic                   hsync_reg;
	logic                   vsync_reg;
	logic                   aux_control_first_reg;
	logic                   aux_control_second_reg;
	logic                   aux_control_third_reg;
	logic                   pix2;
	logic                   stagger_select_n_n;

	// register file
	dvirx_apb_regs u_regs (
		.clock       (clock),
		.rst         (rst),
		.paddr       (paddr),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.link_active (flag_reg),
		.drive_en    (drive_en_reg),
		.ctrl        (ctrl)
	);

	// data enable edge toggle brought into the system domain
	always_ff @(posedge clock) begin
		if (rst) begin
			de_tgl_meta <= 1'b0;
			de_tgl_sync <= 1'b0;
			de_tgl_seen <= 1'b0;
		end else begin
			de_tgl_meta <= de_tgl_reg;
			de_tgl_sync <= de_tgl_meta;
			de_tgl_seen <= de_tgl_sync;
		end
	end
	assign de_evt = de_tgl_sync ^ de_tgl_seen; // one pulse per de edge

	// link activity watch on data enable edges
	always_ff @(posedge clock) begin
		if (rst) begin
			act_state_reg <= dvirx_pkg::ACT_IDLE;
			idle_cnt_reg  <= '0;
			flag_reg      <= 1'b0;
		end else begin
			case (act_state_reg)
				dvirx_pkg::ACT_IDLE: begin
					idle_cnt_reg <= '0;
					if (de_evt) begin // R3
						act_state_reg <= dvirx_pkg::ACT_LIVE;
						flag_reg      <= 1'b1; // R4
					end
				end
				dvirx_pkg::ACT_LIVE: begin
					if (de_evt) begin
						idle_cnt_reg <= '0;
					end else if (idle_cnt_reg == dvirx_pkg::IDLE_LAST) begin
						act_state_reg <= dvirx_pkg::ACT_IDLE; // R15
						flag_reg      <= 1'b0; // R4
						idle_cnt_reg  <= '0;
					end else begin
						idle_cnt_reg <= idle_cnt_reg + 1'b1;
					end
				end
				default: begin
					act_state_reg <= dvirx_pkg::ACT_IDLE;
					idle_cnt_reg  <= '0;
					flag_reg      <= 1'b0;
				end
			endcase
		end
	end

	// driver enable, optionally gated by link activity
	always_ff @(posedge clock) begin
		if (rst) begin
			drive_en_reg <= 1'b0;
		end else begin
			drive_en_reg <= ctrl.output_drive_powerdown_n &&
			                (!ctrl.auto_powerdown || flag_reg); // R5 R14
		end
	end

	assign link_active_flag      = flag_reg;
	assign drive_strength_select = ctrl.drive_strength_select; // R8

	// reset and quasi-static control into the link domain
	always_ff @(posedge link_reference_clock) begin
		link_rst_meta <= rst;
		link_rst_q    <= link_rst_meta;
	end

	always_ff @(posedge link_reference_clock) begin
		if (link_rst_q) begin
			ctrl_meta <= dvirx_pkg::dvirx_ctrl_s'(dvirx_pkg::CTRL_RST);
			ctrl_lk   <= dvirx_pkg::dvirx_ctrl_s'(dvirx_pkg::CTRL_RST);
			en_meta   <= 1'b0;
			en_lk     <= 1'b0;
		end else begin
			ctrl_meta <= ctrl;
			ctrl_lk   <= ctrl_meta;
			en_meta   <= drive_en_reg;
			en_lk     <= en_meta;
		end
	end

	assign pix2   = ctrl_lk.pixel_mode_select;
	assign stagger_select_n_n = ctrl_lk.stagger_select_n;
	// data enable edge detect in the link domain
	always_ff @(posedge link_reference_clock) begin
		if (link_rst_q) begin
			de_prev_reg <= 1'b0;
			de_tgl_reg  <= 1'b0;
		end else begin
			de_prev_reg <= link_in.de;
			if (link_in.de != de_prev_reg) begin
				de_tgl_reg <= !de_tgl_reg; // R3
			end
		end
	end

	// half rate output clock and pair position
	always_ff @(posedge link_reference_clock) begin
		if (link_rst_q) begin
			ck_half_reg  <= 1'b0;
			pair_odd_reg <= 1'b0;
		end else begin
			ck_half_reg  <= !ck_half_reg; // R9
			pair_odd_reg <= link_in.de && !pair_odd_reg; // R12
		end
	end

	// output clock: reference clock or half of it
	assign output_pixel_clock = pix2 ? ck_half_reg
	                                 : link_reference_clock; // R9 R10

	// pair holding registers
	always_ff @(posedge link_reference_clock) begin
		if (link_rst_q) begin
			even_hold_reg <= '0;
			odd_hold_reg  <= '0;
			stagger_select_n_pend_reg <= 1'b0;
		end else begin
			stagger_select_n_pend_reg <= 1'b0;
			if (link_in.de && !pair_odd_reg) begin
				even_hold_reg <= pixel_of(link_in);
			end
			if (pix2 && !stagger_select_n_n && link_in.de && pair_odd_reg) begin
				odd_hold_reg  <= pixel_of(link_in); // R6
				stagger_select_n_pend_reg <= 1'b1;
			end
		end
	end

	// even pixel bus
	always_ff @(posedge link_reference_clock) begin
		if (link_rst_q) begin
			even_reg <= '0;
		end else if (!link_in.de) begin
			even_reg <= '0;
		end else if (!pix2) begin
			even_reg <= pixel_of(link_in); // R12
		end else if (pair_odd_reg) begin
			even_reg <= even_hold_reg; // R7
		end
	end

	// odd pixel bus
	always_ff @(posedge link_reference_clock) begin
		if (link_rst_q) begin
			odd_reg <= '0;
		end else if (!pix2) begin
			odd_reg <= '0; // R13
		end else if (stagger_select_n_pend_reg) begin
			odd_reg <= odd_hold_reg; // R6
		end else if (link_in.de && pair_odd_reg && stagger_select_n_n) begin
			odd_reg <= pixel_of(link_in); // R7
		end else if (!link_in.de) begin
			odd_reg <= '0;
		end
	end

	// data enable taken every cycle, control signals taken during blanking
	always_ff @(posedge link_reference_clock) begin
		if (link_rst_q) begin
			de_out_reg <= 1'b0;
			hsync_reg  <= 1'b0;
			vsync_reg  <= 1'b0;
			aux_control_first_reg   <= 1'b0;
			aux_control_second_reg   <= 1'b0;
			aux_control_third_reg   <= 1'b0;
		end else begin
			de_out_reg <= link_in.de;
			if (!link_in.de) begin
				hsync_reg <= link_in.ch0_ctl[0]; // R11
				vsync_reg <= link_in.ch0_ctl[1]; // R11
				aux_control_first_reg  <= link_in.ch1_ctl[0]; // R1
				aux_control_second_reg  <= link_in.ch2_ctl[0]; // R2
				aux_control_third_reg  <= link_in.ch2_ctl[1]; // R2
			end
		end
	end

	// pin outputs; the pad ring floats all but flag and ctl 1
	assign even_pixel_bus      = even_reg;
	assign odd_pixel_bus       = odd_reg;
	assign de_out              = de_out_reg;
	assign hsync_out           = hsync_reg;
	assign vsync_out           = vsync_reg;
	assign aux_control_first   = aux_control_first_reg;
	assign aux_control_second  = aux_control_second_reg;
	assign aux_control_third   = aux_control_third_reg;
	assign output_drive_enable = en_lk; // R14

	// assertions, link domain
	a_blue_map: assert property (@(posedge link_reference_clock) // R11
		disable iff (link_rst_q)
		(!pix2 && link_in.de) |=> even_pixel_bus[7:0] ==
		$past(link_in.ch0_data))
		else $error("blue not from channel 0");
	a_green_map: assert property (@(posedge link_reference_clock) // R1
		disable iff (link_rst_q)
		(!pix2 && link_in.de) |=> even_pixel_bus[15:8] ==
		$past(link_in.ch1_data))
		else $error("green not from channel 1");
	a_red_map: assert property (@(posedge link_reference_clock) // R2
		disable iff (link_rst_q)
		(!pix2 && link_in.de) |=> even_pixel_bus[23:16] ==
		$past(link_in.ch2_data))
		else $error("red not from channel 2");
	a_blank_ctl: assert property (@(posedge link_reference_clock) // R1 R2
		disable iff (link_rst_q)
		!link_in.de |=> aux_control_first == $past(link_in.ch1_ctl[0])
		&& aux_control_second == $past(link_in.ch2_ctl[0])
		&& aux_control_third == $past(link_in.ch2_ctl[1]))
		else $error("aux control not taken in blanking");
	a_blank_sync: assert property (@(posedge link_reference_clock) // R11
		disable iff (link_rst_q)
		(!link_in.de ##1 link_in.de[*2]) |=> $stable(hsync_out)
		&& hsync_out == $past(link_in.ch0_ctl[0], 3)
		&& vsync_out == $past(link_in.ch0_ctl[1], 3))
		else $error("sync not held from blanking");
	a_odd_low: assert property (@(posedge link_reference_clock) // R13
		disable iff (link_rst_q)
		!pix2 ##1 !pix2 |-> odd_pixel_bus == '0)
		else $error("odd bus not low in one-pixel mode");
	a_half_clock: assert property (@(posedge link_reference_clock) // R9
		disable iff (link_rst_q)
		pix2 ##1 pix2 |-> output_pixel_clock != $past(output_pixel_clock))
		else $error("output clock not half rate");
	sequence s_pair_end;
		pix2 && link_in.de && pair_odd_reg;
	endsequence
	a_pair_simul: assert property (@(posedge link_reference_clock) // R7
		disable iff (link_rst_q)
		(s_pair_end and stagger_select_n_n) |=> odd_pixel_bus == $past(pixel_of(link_in))
		&& even_pixel_bus == $past(even_hold_reg))
		else $error("pair not presented together");
	sequence s_stagger_select_n_pair;
		s_pair_end ##0 !stagger_select_n_n;
	endsequence
	a_stagger_select_n_offset: assert property (@(posedge link_reference_clock) // R6
		disable iff (link_rst_q)
		s_stagger_select_n_pair |=> even_pixel_bus == $past(even_hold_reg)
		##1 odd_pixel_bus == $past(pixel_of(link_in), 2)
		&& $changed(stagger_select_n_pend_reg))
		else $error("odd output not one step after even");
	a_pair_even: assert property (@(posedge link_reference_clock) // R12
		disable iff (link_rst_q)
		(pix2 && link_in.de && !pair_odd_reg) |=> pair_odd_reg
		&& even_hold_reg == $past(pixel_of(link_in)))
		else $error("even pixel not first of pair");
	// assertions, system domain
	a_flag_rise: assert property (@(posedge clock) disable iff (rst) // R3
		de_evt |=> link_active_flag)
		else $error("flag not raised on data enable edge");
	a_flag_drop: assert property (@(posedge clock) disable iff (rst) // R15
		(act_state_reg == dvirx_pkg::ACT_LIVE && !de_evt &&
		idle_cnt_reg == dvirx_pkg::IDLE_LAST) |=> !link_active_flag)
		else $error("flag not cleared after idle time");
	a_flag_hold: assert property (@(posedge clock) disable iff (rst) // R4
		(link_active_flag && idle_cnt_reg != dvirx_pkg::IDLE_LAST)
		|=> link_active_flag)
		else $error("flag dropped early");
	a_auto_off: assert property (@(posedge clock) disable iff (rst) // R5
		(ctrl.auto_powerdown && !link_active_flag)[*2] |->
		!drive_en_reg)
		else $error("drivers on while link inactive");
	// write data seen as control fields, for the strength check
	dvirx_pkg::dvirx_ctrl_s wr_ctrl;
	assign wr_ctrl = dvirx_pkg::dvirx_ctrl_s'(
		pwdata[dvirx_pkg::CTRL_W-1:0]);
	a_strength: assert property (@(posedge clock) disable iff (rst) // R8
		(psel && penable && pwrite && paddr == dvirx_pkg::CTRL_OFF) |=>
		drive_strength_select == $past(wr_ctrl.drive_strength_select))
		else $error("drive strength not followed");

endmodule

//--- test/dvirx_tx_model.sv
// behavioural link transmitter: decoded words, one line per request toggle
`timescale 1ns/100ps
module dvirx_tx_model (
	input  wire logic               link_reference_clock, // pixel clock
	input  wire logic               rst,                  // sync reset, high
	input  wire logic               tx_req,               // toggle: one line
	input  wire logic [5:0]         blank_ctl,            // ctl in blanking
	output dvirx_pkg::dvirx_link_s  link_in,              // decoded word
	output logic                    tx_busy               // line in flight
);
	localparam int LINE_LEN = 4;

	logic       req_seen_reg; // last request served
	logic [3:0] pix_cnt_reg;  // pixels still to send
	logic [7:0] idx;          // pixel index in line

	initial link_in = '0;
	assign idx = 8'(LINE_LEN - pix_cnt_reg);
	assign tx_busy = (pix_cnt_reg != 4'h0) || link_in.de;

	// line sequencing
	always @(posedge link_reference_clock) begin
		if (rst) begin
			req_seen_reg <= 1'b0;
			pix_cnt_reg <= 4'h0;
		end else if (pix_cnt_reg != 4'h0) begin
			pix_cnt_reg <= pix_cnt_reg - 4'h1;
		end else if (tx_req !== req_seen_reg) begin
			req_seen_reg <= tx_req;
			pix_cnt_reg <= 4'(LINE_LEN);
		end
	end

	// colour on the channels when active, controls in blanking
	always @(posedge link_reference_clock) begin
		if (pix_cnt_reg != 4'h0 && !rst) begin
			link_in.de <= 1'b1;
			link_in.ch2_data <= idx + 8'h10;
			link_in.ch1_data <= idx + 8'h20;
			link_in.ch0_data <= idx + 8'h30;
		end else begin
			link_in.de <= 1'b0;
			link_in.ch2_data <= ~link_in.ch2_data;
			link_in.ch1_data <= ~link_in.ch1_data;
			link_in.ch0_data <= ~link_in.ch0_data;
			link_in.ch2_ctl <= blank_ctl[5:4];
			link_in.ch1_ctl <= blank_ctl[3:2];
			link_in.ch0_ctl <= blank_ctl[1:0];
		end
	end
endmodule

//--- test/testbench.sv
// self-checking bench for the receiver output control block
`timescale 1ns/100ps
module testbench;
	typedef struct packed {
		logic [4:0] ctrl;   // control word written
		logic [5:0] ctl;    // blanking control code
		logic [7:0] clk_ns; // expected output clock period
		logic       lag;    // odd lags even by one edge
	} dvirx_row_s;
	localparam dvirx_row_s ROWS [5] = '{
		'{5'h0C, 6'h15, 8'h1E, 1'b0},
		'{5'h0A, 6'h2A, 8'h1E, 1'b0},
		'{5'h0B, 6'h3F, 8'h3C, 1'b0},
		'{5'h09, 6'h00, 8'h3C, 1'b1},
		'{5'h0D, 6'h33, 8'h3C, 1'b1}};

	logic clock = 1'b0;
	logic link_reference_clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, de_out, hsync_out, vsync_out;
	logic aux_control_first, aux_control_second, aux_control_third;
	logic output_pixel_clock, output_drive_enable;
	logic drive_strength_select, link_active_flag;
	dvirx_pkg::dvirx_link_s link_in;
	dvirx_pkg::dvirx_pixel_t even_pixel_bus, odd_pixel_bus, ev_last, od_last;
	dvirx_pkg::dvirx_pixel_t ev_q[$], od_q[$];
	logic tx_req = 1'b0;
	logic [5:0] blank_ctl = 6'h00;
	logic tx_busy;
	int err_total = 0;
	int cmp_count = 0;
	int edge_n = 0;
	int de_n = 0;
	int ev_t, od_t;

	always #20 clock = ~clock;
	always #15 link_reference_clock = ~link_reference_clock;

	dvirx_output_control u_dut (.clock(clock), .rst(rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_reference_clock(link_reference_clock), .link_in(link_in),
		.even_pixel_bus(even_pixel_bus), .odd_pixel_bus(odd_pixel_bus),
		.de_out(de_out), .hsync_out(hsync_out), .vsync_out(vsync_out),
		.aux_control_first(aux_control_first),
		.aux_control_second(aux_control_second),
		.aux_control_third(aux_control_third),
		.output_pixel_clock(output_pixel_clock),
		.output_drive_enable(output_drive_enable),
		.drive_strength_select(drive_strength_select),
		.link_active_flag(link_active_flag));

	dvirx_tx_model u_tx (.link_reference_clock(link_reference_clock),
		.rst(rst), .tx_req(tx_req), .blank_ctl(blank_ctl),
		.link_in(link_in), .tx_busy(tx_busy));

	// collect each new nonzero pixel on both buses and the edge of the first
	always @(posedge link_reference_clock) begin
		edge_n++;
		if (de_out === 1'b1) de_n++;
		if (even_pixel_bus !== 24'h0 && even_pixel_bus !== ev_last) begin
			ev_q.push_back(even_pixel_bus);
			if (ev_t < 0) ev_t = edge_n;
		end
		if (odd_pixel_bus !== 24'h0 && odd_pixel_bus !== od_last) begin
			od_q.push_back(odd_pixel_bus);
			if (od_t < 0) od_t = edge_n;
		end
		ev_last = even_pixel_bus;
		od_last = odd_pixel_bus;
	end

	function automatic logic [31:0] pix(input int k);
		logic [7:0] b;
		b = k[7:0];
		return {8'h00, b + 8'h10, b + 8'h20, b + 8'h30};
	endfunction

	task conclude;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task fail(input string m);
		err_total++;
		$display("ERROR %0t %s", $time, m);
		conclude();
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, entered just after a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 16) fail("apb hang");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task send_line;
		int i;
		logic seen;
		seen = 1'b0;
		ev_q.delete();
		od_q.delete();
		ev_t = -1;
		od_t = -1;
		de_n = 0;
		tx_req <= ~tx_req;
		for (i = 0; i < 60; i++) begin
			@(posedge clock);
			if (tx_busy === 1'b1) seen = 1'b1;
			else if (seen && even_pixel_bus === 24'h0
				&& odd_pixel_bus === 24'h0) break;
		end
		if (i == 60) fail("line hang");
	endtask

	// period between two rising edges of the output clock, in ns
	task measure(output int ns);
		int i, t0;
		logic prv;
		t0 = -1;
		ns = 0;
		#0.5;
		prv = output_pixel_clock;
		for (i = 0; i < 400; i++) begin
			#1;
			if (output_pixel_clock === 1'b1 && prv === 1'b0) begin
				if (t0 >= 0) begin
					ns = i - t0;
					break;
				end
				t0 = i;
			end
			prv = output_pixel_clock;
		end
		@(posedge clock);
	endtask

	initial begin
		logic [31:0] rd;
		logic er;
		dvirx_row_s row;
		int i, r, ns;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		apb(1'b0, dvirx_pkg::CTRL_OFF, 32'h0, rd, er);
		check(rd, 32'(dvirx_pkg::CTRL_RST));
		check(32'(link_active_flag), 32'h0);
		check(32'(odd_pixel_bus), 32'h0);
		apb(1'b0, 8'h08, 32'h0, rd, er);
		check(32'(er), 32'h1);
		check(rd, 32'h0);
		apb(1'b1, 8'h0C, 32'hFFFF_FFFF, rd, er);
		check(32'(er), 32'h1);
		$display("test reset and map done");
		for (r = 0; r < 5; r++) begin
			row = ROWS[r];
			blank_ctl <= row.ctl;
			apb(1'b1, dvirx_pkg::CTRL_OFF, 32'(row.ctrl), rd, er);
			repeat (10) @(posedge clock);
			send_line();
			check(32'(de_n), 32'h4);
			check(32'(ev_q.size()), row.ctrl[0] ? 2 : 4);
			for (i = 0; i < ev_q.size(); i++) begin
				check(32'(ev_q[i]), pix(row.ctrl[0] ? 2 * i : i));
			end
			check(32'(od_q.size()), row.ctrl[0] ? 2 : 0);
			for (i = 0; i < od_q.size(); i++) begin
				check(32'(od_q[i]), pix(2 * i + 1));
			end
			if (row.ctrl[0]) check(32'(od_t - ev_t), 32'(row.lag));
			check(32'({aux_control_third, aux_control_second,
				aux_control_first, vsync_out, hsync_out}),
				32'({row.ctl[5:4], row.ctl[2:0]}));
			check(32'(drive_strength_select), 32'(row.ctrl[2]));
			measure(ns);
			check(32'(ns), 32'(row.clk_ns));
			apb(1'b0, dvirx_pkg::CTRL_OFF, 32'h0, rd, er);
			check(rd, 32'(row.ctrl));
			$display("test row %0d done", r);
		end
		check(32'(link_active_flag), 32'h1);
		apb(1'b0, dvirx_pkg::STATUS_OFF, 32'h0, rd, er);
		check(32'(rd[0]), 32'h1);
		for (i = 0; i < 3000; i++) begin
			@(posedge clock);
			if (link_active_flag === 1'b0) break;
		end
		if (i == 3000) fail("idle hang");
		check(32'(i > dvirx_pkg::IDLE_CYCLES - 60
			&& i <= dvirx_pkg::IDLE_CYCLES + 8), 32'h1);
		$display("test idle timeout done");
		apb(1'b1, dvirx_pkg::CTRL_OFF, 32'h1A, rd, er);
		repeat (10) @(posedge clock);
		check(32'(output_drive_enable), 32'h0);
		send_line();
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (output_drive_enable === 1'b1) break;
		end
		check(32'(output_drive_enable), 32'h1);
		apb(1'b1, dvirx_pkg::CTRL_OFF, 32'h02, rd, er);
		repeat (10) @(posedge clock);
		check(32'(output_drive_enable), 32'h0);
		apb(1'b0, dvirx_pkg::STATUS_OFF, 32'h0, rd, er);
		check(32'(rd[1]), 32'h0);
		$display("test output power-down done");
		conclude();
	end
endmodule
